//--- rtl/pmv_defines.svh
// Constants of the power mode and voltage monitor block.
// Assumes inclusion by bare name; definitions only.
`ifndef PMV_DEFINES_SVH
`define PMV_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMV_OFS_CTRL   8'h00
`define PMV_OFS_STAT   8'h04
`define PMV_OFS_CFG    8'h24
`define PMV_OFS_MEM    8'h30

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMV_RST_CTRL   32'h0000_0000
`define PMV_RST_CFG    32'h0000_0040
`define PMV_RST_MEM    32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMV_CTRL_REGULATOR_LOW_POWER_SELECT  0
`define PMV_CTRL_DEN   4
`define PMV_CTRL_LS_LO 9
`define PMV_CTRL_LS_HI 12
`define PMV_STAT_DOF   2

// ----------------------------------------
// System clock source codes
// ----------------------------------------
`define PMV_SRC_HSIDIV 2'h0
`define PMV_SRC_HSI    2'h1
`define PMV_SRC_HSE    2'h2
`define PMV_SRC_LSI    2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMV_CLK_PERIOD_NS 50
`define PMV_REG_START_NS  10000
`define PMV_REG_START_CYC ((`PMV_REG_START_NS + `PMV_CLK_PERIOD_NS - 1) / `PMV_CLK_PERIOD_NS)

`endif

//--- rtl/pmv_pkg.sv
// Types of the power mode and voltage monitor block.
// Assumes pmv_defines.svh supplies the numbers.
package pmv_pkg;

  // Power mode state
  typedef enum logic [2:0] {
    PMV_RUN      = 3'b000,
    PMV_SLEEP    = 3'b001,
    PMV_STOP     = 3'b010,
    PMV_DSTOP    = 3'b011,
    PMV_WAKE_OSC = 3'b100,
    PMV_WAKE_REG = 3'b101
  } pmv_mode_e;

  // Requests and controls from the processor core
  typedef struct packed {
    logic wait_for_interrupt_request;
    logic wait_for_event_request;
    logic handler_exit;
    logic deep_sleep_bit;
    logic sleep_on_handler_return;
    logic keep_core_clock;
  } pmv_core_s;

  // Wake sources
  typedef struct packed {
    logic any_interrupt;
    logic wake_event;
    logic ext_line_irq;
    logic ext_line_event;
    logic external_pending_flags;
  } pmv_wake_s;

  // Clock and supply controls to the clock unit and regulator
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic hs_osc_allow;
    logic lsi_keep;
    logic independent_watchdog_keep;
    logic regulator_en;
    logic regulator_low_power;
    logic io_hold;
  } pmv_ctl_s;

endpackage : pmv_pkg

//--- rtl/pmv_top.sv
// Power mode sequencer and supply voltage detector control, APB slave.
// Assumes core, interrupt controller and clock unit share pclk; the analog
// comparator output arrives asynchronously and is synchronised here.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "pmv_defines.svh"

// Notes on behaviour
// - Any reset leaves the block in Run with all clocks on.
// - Regulator stays enabled in every mode; only its level changes.
// - Detector compares only when enabled, against the level select field.
// - Level select bits 12:9, 1.8V to 4.8V, codes above 1010 reserved.
// - A flag shows whether supply is above or below threshold.
// - Detector output drives external interrupt line 16 level.
// - Wait request with deep-sleep and sleep-on-exit clear enters Sleep.
// - Sleep-on-exit set: handler exit enters Sleep, interrupt-wait form only.
// - Sleep gates only the processor clock.
// - Sleep ends at once: interrupt after interrupt-wait, event after event-wait.
// - Stop entered with deep-sleep set, low-power clear, HSI or LSI source (not divided HSI).
// - Pending external flags at Stop entry skip the entry.
// - Stop halts core domain clocks and both high-speed oscillators.
// - Stop exit selects internal oscillator divided by six.
// - Wake waits oscillator start, plus regulator delay at normal power.
// - Stop ends on interrupt-mode line or event-mode line by entry form.
// - Deep Stop entered with deep-sleep and low-power bits set.
// - Deep Stop ends on any external interrupt or event; divide-by-six clock.
// - Watchdog and low-speed oscillator keep running if enabled before entry.
// - I/O pins hold their Run state in every low-power mode.
// - Control bits 31:13 read zero; low-power bit 0, enable bit 4.
// - Core unclocked in stopped modes unless debug keeps it clocked.
// - Low-power bit set puts regulator in low-power for stopped modes.
// - Status bit 2 reads 1 below threshold, 0 above; read-only.
// - Flag reads 0 after reset until detector enabled.
module pmv_top #(
  parameter int unsigned REG_START_CYC = `PMV_REG_START_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire pmv_pkg::pmv_core_s  core_in,
  input  wire pmv_pkg::pmv_wake_s  wake_in,
  input  wire logic [1:0]          system_clock_signal_source,
  input  wire logic                hsi_ready,
  input  wire logic                lsi_enabled,
  input  wire logic                independent_watchdog_enabled,
  input  wire logic                detector_compare_raw,
  output pmv_pkg::pmv_ctl_s        ctl_out,
  output logic                     select_hsi_div6,
  output logic [3:0]               detector_level_select,
  output logic                     detector_enable,
  output logic                     external_interrupt_controller_line16,
  output pmv_pkg::pmv_mode_e       mode
);
  import pmv_pkg::*;

  // ----------------------------------------
  // Local declarations
  // ----------------------------------------
  localparam int CW = $clog2(REG_START_CYC + 1);
  // Control reset word kept as a vector so each field is sliced from it
  localparam logic [31:0] CTRL_RST = `PMV_RST_CTRL;

  logic              regulator_low_power_select_r;
  logic              den_r;
  logic [3:0]        pls_r;
  logic [31:0]       cfg_r;
  logic [31:0]       mem_r;
  logic [2:0]        det_sync_r;
  logic              det_stable_r;
  logic              dof;
  logic              wr_en;
  logic              rd_hit;
  logic [31:0]       rd_data;
  logic              entered_wfe_r;
  logic              lp_regulator_r;
  logic [CW-1:0]     reg_cnt_r;
  logic              hsi_sel_r;
  pmv_mode_e         mode_r;
  pmv_mode_e         mode_nxt;
  logic              wait_req;
  logic              stop_ok;
  logic              wake_stop;
  logic              wake_dstop;
  logic              wake_sleep;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states; writes take effect in the access phase
  // Status writes are dropped quietly; only unmapped offsets raise an error
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;

  // Read decode; unmapped offsets read zero and raise pslverr
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `PMV_OFS_CTRL: begin
        rd_data[`PMV_CTRL_REGULATOR_LOW_POWER_SELECT] = regulator_low_power_select_r;
        rd_data[`PMV_CTRL_DEN]  = den_r;
        rd_data[`PMV_CTRL_LS_HI:`PMV_CTRL_LS_LO] = pls_r;
      end
      `PMV_OFS_STAT: begin
        rd_data[`PMV_STAT_DOF] = dof;
      end
      `PMV_OFS_CFG:  rd_data = cfg_r;
      `PMV_OFS_MEM:  rd_data = mem_r;
      default:       rd_hit  = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~rd_hit;

  // Read data registered in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_data;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // low-power and enable bits read-write, level field at 12:9
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_low_power_select_r <= CTRL_RST[`PMV_CTRL_REGULATOR_LOW_POWER_SELECT];
      den_r  <= CTRL_RST[`PMV_CTRL_DEN];
      pls_r  <= CTRL_RST[`PMV_CTRL_LS_HI:`PMV_CTRL_LS_LO];
    end else if (wr_en && paddr == `PMV_OFS_CTRL) begin
      regulator_low_power_select_r <= pwdata[`PMV_CTRL_REGULATOR_LOW_POWER_SELECT];
      den_r  <= pwdata[`PMV_CTRL_DEN];
      pls_r  <= pwdata[`PMV_CTRL_LS_HI:`PMV_CTRL_LS_LO];
    end
  end

  // Configuration and memory control are plain storage for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `PMV_RST_CFG;
      mem_r <= `PMV_RST_MEM;
    end else if (wr_en) begin
      if (paddr == `PMV_OFS_CFG) begin
        cfg_r <= pwdata;
      end
      if (paddr == `PMV_OFS_MEM) begin
        mem_r <= pwdata;
      end
    end
  end

  // comparator enabled and threshold taken from the level field
  assign detector_enable       = den_r;
  assign detector_level_select = pls_r;

  // ----------------------------------------
  // Detector output synchroniser
  // ----------------------------------------
  // three stages, change accepted once stages two and three agree
  // so a slow ragged crossing gives exactly one edge
  // A pulse shorter than two clocks may vanish; the comparator moves slowly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_sync_r   <= 3'h0;
      det_stable_r <= 1'b0;
    end else begin
      det_sync_r <= {det_sync_r[1:0], detector_compare_raw};
      if (det_sync_r[1] == det_sync_r[2]) begin
        det_stable_r <= det_sync_r[2];
      end
    end
  end

  // flag held at zero while disabled; shows side of threshold
  assign dof = den_r & det_stable_r;

  // flag level feeds line 16; edge selection lives in the controller
  assign external_interrupt_controller_line16 = dof;

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  assign wait_req = core_in.wait_for_interrupt_request | core_in.wait_for_event_request;

  // Stop only from the HSI or LSI source; the divided HSI source is refused
  // pending external flags skip the entry
  assign stop_ok = ~wake_in.external_pending_flags &
                   (system_clock_signal_source == `PMV_SRC_HSI || system_clock_signal_source == `PMV_SRC_LSI);

  // wake source depends on entry form
  assign wake_sleep = entered_wfe_r ? wake_in.wake_event : wake_in.any_interrupt;
  // interrupt-mode line after interrupt-wait, event-mode after event-wait
  assign wake_stop  = entered_wfe_r ? wake_in.ext_line_event : wake_in.ext_line_irq;
  // any external interrupt or event ends Deep Stop
  assign wake_dstop = wake_in.ext_line_irq | wake_in.ext_line_event | wake_in.wake_event;

  // Next mode
  // Deep-sleep requests win over plain Sleep; a refused Stop entry
  // leaves the core running so software can clear pending flags first
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      PMV_RUN: begin
        if (wait_req && core_in.deep_sleep_bit) begin
          // both bits set selects Deep Stop
          if (regulator_low_power_select_r) begin
            mode_nxt = PMV_DSTOP;
          end else if (stop_ok) begin
            mode_nxt = PMV_STOP;
          end
        end else if (wait_req && !core_in.sleep_on_handler_return) begin
          mode_nxt = PMV_SLEEP;
        end else if (core_in.handler_exit && core_in.sleep_on_handler_return &&
                     !core_in.deep_sleep_bit) begin
          mode_nxt = PMV_SLEEP;
        end
      end
      PMV_SLEEP: begin
        if (wake_sleep) begin
          mode_nxt = PMV_RUN;
        end
      end
      PMV_STOP: begin
        if (wake_stop) begin
          mode_nxt = PMV_WAKE_OSC;
        end
      end
      PMV_DSTOP: begin
        if (wake_dstop) begin
          mode_nxt = PMV_WAKE_OSC;
        end
      end
      PMV_WAKE_OSC: begin
        // wait for oscillator, then regulator if it stayed normal
        if (hsi_ready) begin
          mode_nxt = lp_regulator_r ? PMV_RUN : PMV_WAKE_REG;
        end
      end
      PMV_WAKE_REG: begin
        // Counter runs from zero on entry, so Run follows REG_START_CYC cycles on
        if (reg_cnt_r == CW'(REG_START_CYC - 1)) begin
          mode_nxt = PMV_RUN;
        end
      end
      default: mode_nxt = PMV_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= PMV_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Entry form, latched on entry; handler-exit entry counts as interrupt-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entered_wfe_r <= 1'b0;
    end else if (mode_r == PMV_RUN && mode_nxt != PMV_RUN) begin
      entered_wfe_r <= core_in.wait_for_event_request & ~core_in.wait_for_interrupt_request &
                       wait_req;
    end
  end

  // regulator level fixed at entry from the low-power bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_regulator_r <= 1'b0;
    end else if (mode_r == PMV_RUN && mode_nxt == PMV_DSTOP) begin
      lp_regulator_r <= 1'b1;
    end else if (mode_nxt == PMV_RUN) begin
      lp_regulator_r <= 1'b0;
    end
  end

  // regulator start-up delay counter
  // Held at zero outside the restart state so each wake starts afresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_cnt_r <= '0;
    end else if (mode_r == PMV_WAKE_REG) begin
      reg_cnt_r <= reg_cnt_r + CW'(1);
    end else begin
      reg_cnt_r <= '0;
    end
  end

  // divide-by-six select pulses when a stopped mode wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsi_sel_r <= 1'b0;
    end else begin
      hsi_sel_r <= (mode_r == PMV_STOP || mode_r == PMV_DSTOP) && mode_nxt == PMV_WAKE_OSC;
    end
  end

  assign select_hsi_div6 = hsi_sel_r;
  assign mode            = mode_r;

  // ----------------------------------------
  // Clock and supply controls
  // ----------------------------------------
  // Decoded from the state flop; the clock unit should register these
  // if a one-cycle glitch on a mode change would harm it
  always_comb begin
    // processor clock runs only in Run; Sleep, stopped and wake modes gate it
    // debug may keep the core clocked
    ctl_out.cpu_clk_en    = (mode_r == PMV_RUN) | core_in.keep_core_clock;
    // core domain clocks off while stopped or restarting
    ctl_out.periph_clk_en = (mode_r == PMV_RUN) | (mode_r == PMV_SLEEP);
    ctl_out.hs_osc_allow  = (mode_r != PMV_STOP) & (mode_r != PMV_DSTOP);
    // low-speed oscillator and watchdog follow their own enables
    ctl_out.lsi_keep      = lsi_enabled;
    ctl_out.independent_watchdog_keep     = independent_watchdog_enabled;
    ctl_out.regulator_en  = 1'b1;
    // low-power level only in Deep Stop
    ctl_out.regulator_low_power = (mode_r == PMV_DSTOP);
    // pins hold their Run state outside Run
    ctl_out.io_hold       = (mode_r != PMV_RUN);
  end

endmodule // pmv_top

//--- verification/pmv_checker.sv
// Port checker for the power mode and voltage monitor block.
// Assumes it is bound to pmv_top and sees only its ports.
`timescale 1ns/1ns
module pmv_checker
  import pmv_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire pmv_pkg::pmv_core_s core_in,
  input wire pmv_pkg::pmv_wake_s wake_in,
  input wire logic              detector_compare_raw,
  input wire logic              detector_enable,
  input wire logic              external_interrupt_controller_line16,
  input wire logic              select_hsi_div6,
  input wire pmv_pkg::pmv_ctl_s  ctl_out,
  input wire pmv_pkg::pmv_mode_e mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_deep;
    mode inside {PMV_STOP, PMV_DSTOP};
  endsequence
  sequence s_leave;
    s_deep ##1 mode == PMV_WAKE_OSC;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_sleep_in;
    mode == PMV_RUN && core_in.wait_for_interrupt_request && !core_in.deep_sleep_bit
      && !core_in.sleep_on_handler_return |=> mode == PMV_SLEEP;
  endproperty
  property p_sleep_gate;
    mode == PMV_SLEEP && !core_in.keep_core_clock |-> !ctl_out.cpu_clk_en && ctl_out.periph_clk_en;
  endproperty
  property p_reg_on;
    ctl_out.regulator_en;
  endproperty
  property p_skip;
    mode == PMV_RUN && core_in.wait_for_interrupt_request && core_in.deep_sleep_bit
      && wake_in.external_pending_flags |=> mode != PMV_STOP;
  endproperty
  property p_deep_lp;
    mode == PMV_DSTOP |-> ctl_out.regulator_low_power;
  endproperty
  property p_div6;
    s_leave |-> ##[0:1] select_hsi_div6;
  endproperty
  property p_stop_clk;
    mode == PMV_STOP |-> !ctl_out.hs_osc_allow && !ctl_out.periph_clk_en;
  endproperty
  property p_hold;
    mode inside {PMV_SLEEP, PMV_STOP, PMV_DSTOP} |-> ctl_out.io_hold;
  endproperty
  property p_flag_off;
    !detector_enable |-> !external_interrupt_controller_line16;
  endproperty
  // Eight quiet cycles cover the three-flop synchroniser with margin
  property p_line;
    $stable(detector_compare_raw) [*8] ##0 detector_enable |-> external_interrupt_controller_line16 == detector_compare_raw;
  endproperty

  a_sleep_in:   assert property (p_sleep_in)   else $error("sleep entry missed");
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep clock gating wrong");
  a_reg_on:     assert property (p_reg_on)     else $error("regulator disabled");
  a_skip:       assert property (p_skip)       else $error("stop entered with pending flags");
  a_deep_lp:    assert property (p_deep_lp)    else $error("deep stop regulator not low power");
  a_div6:       assert property (p_div6)       else $error("no divided clock select on wake");
  a_stop_clk:   assert property (p_stop_clk)   else $error("stop clocks still running");
  a_hold:       assert property (p_hold)       else $error("pins not held in low power");
  a_flag_off:   assert property (p_flag_off)   else $error("line high while detector off");
  a_line:       assert property (p_line)       else $error("line does not follow detector");
endmodule // pmv_checker

bind pmv_top pmv_checker u_chk (.pclk, .presetn, .core_in, .wake_in, .detector_compare_raw, .detector_enable,
  .external_interrupt_controller_line16, .select_hsi_div6, .ctl_out, .mode);

//--- verification/pmv_far_model.sv
// Model of the processor core, interrupt controller and oscillator.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`timescale 1ns/1ns
module pmv_far_model
  import pmv_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire pmv_pkg::pmv_ctl_s  ctl_out,
  output pmv_pkg::pmv_core_s     core_in,
  output pmv_pkg::pmv_wake_s     wake_in,
  output logic                  hsi_ready
);
  logic [1:0] osc_cnt_r;

  initial core_in = '0;
  initial wake_in = '0;

  // Request pulse lasts one cycle; levels in the same word persist
  task req(input logic [5:0] c);
    @(posedge pclk);
    core_in <= c;
    @(posedge pclk);
    core_in <= c & 6'h07;
  endtask

  // Wake source levels; returns at the edge where the block first sees them
  task wake(input logic [4:0] w);
    @(posedge pclk);
    wake_in <= w;
    @(posedge pclk);
  endtask

  // Oscillator needs three cycles after it is allowed, so wake is never instant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) osc_cnt_r <= 2'h0;
    else if (!ctl_out.hs_osc_allow) osc_cnt_r <= 2'h0;
    else if (osc_cnt_r != 2'h3) osc_cnt_r <= osc_cnt_r + 2'h1;
  end
  assign hsi_ready = (osc_cnt_r == 2'h3);
endmodule // pmv_far_model

//--- verification/test_power_mode_and_voltage_monitor.sv
// Self-checking bench for the power mode and voltage monitor block.
// Assumes pmv_far_model plays the core side and the checker is bound.
`timescale 1ns/1ns
module test_power_mode_and_voltage_monitor;
  import pmv_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0]  system_clock_signal_source = 2'h1;
  logic        lsi_enabled = 0, independent_watchdog_enabled = 0, detector_compare_raw = 0, hsi_ready;
  logic        select_hsi_div6, detector_enable, external_interrupt_controller_line16;
  logic [3:0]  detector_level_select;
  pmv_core_s   core_in;
  pmv_wake_s   wake_in;
  pmv_ctl_s    ctl_out;
  pmv_mode_e   mode;
  int          errors = 0, tests_run = 0;

  pmv_top #(.REG_START_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .core_in, .wake_in, .system_clock_signal_source, .hsi_ready, .lsi_enabled, .independent_watchdog_enabled,
    .detector_compare_raw, .ctl_out, .select_hsi_div6, .detector_level_select, .detector_enable,
    .external_interrupt_controller_line16, .mode);
  pmv_far_model far (.pclk, .presetn, .ctl_out, .core_in, .wake_in, .hsi_ready);

  always #25 pclk = ~pclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, '0);
    chk(nm, rd, e);
  endtask

  // Bounded wait for a mode; a timeout ends the run
  task wait_mode(input pmv_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 50) begin
      @(negedge pclk);
      n++;
    end
    chk("mode", 32'(mode), 32'(m));
    if (mode !== m) test_done;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rchk("ctrl", 8'h00, 0);
    rchk("stat", 8'h04, 0);
    rchk("cfg", 8'h24, 32'h40);
    rchk("mem", 8'h30, 0);
    apb(1, 8'h00, 32'hffff_ffff);
    rchk("ctrl", 8'h00, 32'h0000_1e11);
    apb(1, 8'h04, 32'hffff_ffff);
    rchk("stat", 8'h04, 0);
    apb(1, 8'h30, 32'h1234_5678);
    rchk("mem", 8'h30, 32'h1234_5678);
    apb(0, 8'h08, '0);
    chk("slverr", 32'(err), 1);
    chk("unmapped", rd, 0);
    for (int c = 0; c < 11; c++) begin
      apb(1, 8'h00, {19'h0, c[3:0], 9'h0});
      @(negedge pclk);
      chk("level", 32'(detector_level_select), c);
      chk("enable", 32'(detector_enable), 0);
    end
    $display("t_regs done");
  endtask

  task t_det;
    apb(1, 8'h00, 32'h10);
    detector_compare_raw <= 1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("line16", 32'(external_interrupt_controller_line16), 1);
    rchk("flag", 8'h04, 32'h4);
    detector_compare_raw <= 0;
    repeat (6) @(posedge pclk);
    rchk("flag", 8'h04, 0);
    detector_compare_raw <= 1;
    apb(1, 8'h00, 0);
    repeat (6) @(posedge pclk);
    rchk("flag", 8'h04, 0);
    chk("line16", 32'(external_interrupt_controller_line16), 0);
    detector_compare_raw <= 0;
    $display("t_det done");
  endtask

  task t_sleep;
    far.req(6'h20);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_SLEEP));
    chk("cpu", 32'(ctl_out.cpu_clk_en), 0);
    chk("periph", 32'(ctl_out.periph_clk_en), 1);
    chk("hold", 32'(ctl_out.io_hold), 1);
    far.wake(5'h08);
    repeat (2) @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_SLEEP));
    far.wake(5'h10);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_RUN));
    far.wake(0);
    far.req(6'h10);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_SLEEP));
    far.wake(5'h08);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_RUN));
    far.wake(0);
    far.req(6'h02);
    far.req(6'h0a);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_SLEEP));
    far.wake(5'h10);
    wait_mode(PMV_RUN);
    far.wake(0);
    far.req(6'h00);
    $display("t_sleep done");
  endtask

  task t_stop;
    apb(1, 8'h00, 0);
    system_clock_signal_source <= 2'h2;
    lsi_enabled <= 1;
    independent_watchdog_enabled <= 1;
    far.wake(5'h01);
    far.req(6'h24);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_RUN));
    far.wake(0);
    far.req(6'h24);
    system_clock_signal_source <= 2'h1;
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_RUN));
    far.req(6'h25);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_STOP));
    chk("osc", 32'(ctl_out.hs_osc_allow), 0);
    chk("lowpow", 32'(ctl_out.regulator_low_power), 0);
    chk("lsi", 32'(ctl_out.lsi_keep), 1);
    chk("independent_watchdog", 32'(ctl_out.independent_watchdog_keep), 1);
    chk("cpu", 32'(ctl_out.cpu_clk_en), 1);
    chk("regen", 32'(ctl_out.regulator_en), 1);
    far.wake(5'h04);
    wait_mode(PMV_WAKE_OSC);
    chk("div6", 32'(select_hsi_div6), 1);
    wait_mode(PMV_WAKE_REG);
    wait_mode(PMV_RUN);
    far.wake(0);
    far.req(6'h00);
    system_clock_signal_source <= 2'h3;
    far.req(6'h14);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_STOP));
    far.wake(5'h04);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_STOP));
    far.wake(5'h02);
    wait_mode(PMV_WAKE_OSC);
    chk("div6", 32'(select_hsi_div6), 1);
    wait_mode(PMV_RUN);
    far.wake(0);
    $display("t_stop done");
  endtask

  task t_dstop;
    apb(1, 8'h00, 32'h1);
    far.req(6'h14);
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_DSTOP));
    chk("lowpow", 32'(ctl_out.regulator_low_power), 1);
    chk("osc", 32'(ctl_out.hs_osc_allow), 0);
    chk("cpu", 32'(ctl_out.cpu_clk_en), 0);
    far.wake(5'h08);
    wait_mode(PMV_WAKE_OSC);
    chk("div6", 32'(select_hsi_div6), 1);
    wait_mode(PMV_RUN);
    far.wake(0);
    far.req(6'h00);
    $display("t_dstop done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk("mode", 32'(mode), 32'(PMV_RUN));
    chk("cpu", 32'(ctl_out.cpu_clk_en), 1);
    t_regs;
    t_det;
    t_sleep;
    t_stop;
    t_dstop;
    test_done;
  end
endmodule // test_power_mode_and_voltage_monitor
